//--- rtl/ccc0_pkg.sv
// Constants, register map and carrier types for the CAN mode control zero block.
// Assumes one 25 MHz bus clock shared by the bus slave and the protocol engine.
package ccc0_pkg;

  localparam logic [7:0] CCC0_OFS_CTL0  = 8'h00;
  localparam logic [7:0] CCC0_OFS_CTL1  = 8'h04;
  localparam logic [7:0] CCC0_OFS_TIMER = 8'h08;

  localparam int CCC0_BIT_FRAME = 7;
  localparam int CCC0_BIT_RECEIVER_ACTIVE_STATUS = 6;
  localparam int CCC0_BIT_SWAIT = 5;
  localparam int CCC0_BIT_SYNC  = 4;
  localparam int CCC0_BIT_TIMER = 3;
  localparam int CCC0_BIT_WAKE  = 2;
  localparam int CCC0_BIT_SLEEP = 1;
  localparam int CCC0_BIT_INIT  = 0;

  localparam int CCC0_BIT_INIT_ACK  = 0;
  localparam int CCC0_BIT_SLEEP_ACK = 1;
  localparam int CCC0_BIT_WAKE_FLAG = 2;

  localparam logic       CCC0_RST_INIT  = 1'b1;
  localparam logic [3:0] CCC0_TS_BYTE_HI = 4'he;
  localparam logic [3:0] CCC0_TS_BYTE_LO = 4'hf;
  localparam logic       CCC0_RECESSIVE  = 1'b1;

  typedef struct packed {
    logic frame_received;
    logic receiving;
    logic synced;
    logic bit_tick;
    logic msg_acked;
    logic bus_idle;
    logic tx_empty;
    logic tx_bit;
  } ccc0_engine_t;

  typedef struct packed {
    logic [2:0]  sync;
    logic        rx_level;
    logic        frame_flag;
    logic        rx_act;
    logic        stop_in_wait;
    logic        synced;
    logic        timer_en;
    logic        wake_en;
    logic        sleep_req;
    logic        init_req;
    logic        init_ack;
    logic        sleep_ack;
    logic        wake_flag;
    logic        wake_latched;
    logic [15:0] timer;
    logic        ts_pend;
    logic [7:0]  ts_lo;
    logic        buf_wr;
    logic [3:0]  buf_addr;
    logic [7:0]  buf_data;
    logic        tx_pin;
    logic        clk_en;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] hrdata;
  } ccc0_state_t;

endpackage : ccc0_pkg

//--- rtl/ccc0_ctl.sv
// Mode control zero register, init and sleep handshakes, time stamp and pin guard.
// Assumes an AHB-Lite master on hclk and a protocol engine on the same clock.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
module ccc0_ctl
  import ccc0_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire ccc0_engine_t engine,
  input  wire logic         wait_mode,
  input  wire logic         stop_mode,
  input  wire logic         can_receive_pin,
  output logic              can_transmit_pin,
  output logic              engine_abort,
  output logic              sleep_mode,
  output logic              bus_if_clock_enable,
  output logic              buf_wr,
  output logic [3:0]        buf_addr,
  output logic [7:0]        buf_data
);

  ccc0_state_t s;
  ccc0_state_t n;

  function automatic logic [31:0] ccc0_read(input ccc0_state_t st, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      CCC0_OFS_CTL0: begin
        d[CCC0_BIT_FRAME] = st.frame_flag;
        d[CCC0_BIT_RECEIVER_ACTIVE_STATUS] = st.rx_act;
        d[CCC0_BIT_SWAIT] = st.stop_in_wait;
        d[CCC0_BIT_SYNC]  = st.synced;
        d[CCC0_BIT_TIMER] = st.timer_en;
        d[CCC0_BIT_WAKE]  = st.wake_en;
        d[CCC0_BIT_SLEEP] = st.sleep_req;
        d[CCC0_BIT_INIT]  = st.init_req;
      end
      CCC0_OFS_CTL1: begin
        d[CCC0_BIT_INIT_ACK]  = st.init_ack;
        d[CCC0_BIT_SLEEP_ACK] = st.sleep_ack;
        d[CCC0_BIT_WAKE_FLAG] = st.wake_flag;
      end
      CCC0_OFS_TIMER: d[15:0] = st.timer;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : ccc0_read

  always_comb begin
    logic in_init;
    logic [31:0] w;
    in_init = s.init_req & s.init_ack;
    w = hwdata;
    n = s;
    n.buf_wr = 1'b0;
    // Only the second and third stages are compared, so a glitch must last two cycles.
    n.sync = {s.sync[1:0], can_receive_pin};
    if (s.sync[1] == s.sync[2]) begin
      n.rx_level = s.sync[2];
    end

    if (s.dp_write) begin
      case (s.dp_addr)
        CCC0_OFS_CTL0: begin
          if (!in_init) begin
            if (w[CCC0_BIT_FRAME]) begin
              n.frame_flag = 1'b0;
            end
            n.stop_in_wait = w[CCC0_BIT_SWAIT];
            n.timer_en     = w[CCC0_BIT_TIMER];
            n.wake_en      = w[CCC0_BIT_WAKE];
            // Sleep cannot be requested while a wake-up is pending nor withdrawn early.
            if (w[CCC0_BIT_SLEEP] && !s.wake_flag) begin
              n.sleep_req = 1'b1;
            end else if (!w[CCC0_BIT_SLEEP] && (s.sleep_ack || !s.sleep_req)) begin
              n.sleep_req = 1'b0;
            end
          end
          if (w[CCC0_BIT_INIT]) begin
            n.init_req = 1'b1;
          end else if (s.init_ack) begin
            n.init_req = 1'b0;
          end
        end
        CCC0_OFS_CTL1: begin
          if (w[CCC0_BIT_WAKE_FLAG]) begin
            n.wake_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (s.init_req && !s.init_ack) begin
      n.init_ack = 1'b1;
    end else if (!s.init_req && s.init_ack) begin
      n.init_ack = 1'b0;
    end

    if (s.sleep_req && !s.sleep_ack && engine.bus_idle && engine.tx_empty && !in_init) begin
      n.sleep_ack    = 1'b1;
      n.wake_latched = s.wake_en;
    end else if (!s.sleep_req && s.sleep_ack) begin
      n.sleep_ack = 1'b0;
    end

    // Dominant level on the bus counts as traffic; the wake flag wins over its clear.
    if (s.sleep_ack && s.sleep_req && s.wake_latched && !s.rx_level) begin
      n.sleep_req = 1'b0;
      n.wake_flag = 1'b1;
    end

    if (engine.frame_received) begin
      n.frame_flag = 1'b1;
    end
    n.rx_act = engine.receiving;
    n.synced = engine.synced & ~n.init_req;

    if (!n.timer_en) begin
      n.timer = 16'h0000;
    end else if (engine.bit_tick) begin
      n.timer = s.timer + 16'h0001;
    end

    // The stamp goes out as two byte writes, high byte first.
    if (engine.msg_acked && s.timer_en) begin
      n.buf_wr   = 1'b1;
      n.buf_addr = CCC0_TS_BYTE_HI;
      n.buf_data = s.timer[15:8];
      n.ts_lo    = s.timer[7:0];
      n.ts_pend  = 1'b1;
    end else if (s.ts_pend) begin
      n.buf_wr   = 1'b1;
      n.buf_addr = CCC0_TS_BYTE_LO;
      n.buf_data = s.ts_lo;
      n.ts_pend  = 1'b0;
    end

    if (n.init_req && n.init_ack) begin
      n.frame_flag   = 1'b0;
      n.rx_act       = 1'b0;
      n.stop_in_wait = 1'b0;
      n.synced       = 1'b0;
      n.timer_en     = 1'b0;
      n.timer        = 16'h0000;
      n.ts_pend      = 1'b0;
    end

    if ((wait_mode && n.stop_in_wait) || stop_mode || n.init_req || s.sleep_ack) begin
      n.tx_pin = CCC0_RECESSIVE;
    end else begin
      n.tx_pin = engine.tx_bit;
    end
    n.clk_en = ~(wait_mode & n.stop_in_wait);

    if (hready) begin
      n.dp_write = hsel & htrans[1] & hwrite;
      n.dp_addr  = haddr[7:0];
      // Read data are taken from the next state so a read right after a write sees it.
      if (hsel && htrans[1] && !hwrite) begin
        n.hrdata = ccc0_read(n, haddr[7:0]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s          <= '0;
      s.sync     <= 3'b111;
      s.rx_level <= CCC0_RECESSIVE;
      s.init_req <= CCC0_RST_INIT;
      s.init_ack <= CCC0_RST_INIT;
      s.tx_pin   <= CCC0_RECESSIVE;
      s.clk_en   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = s.hrdata;
  assign can_transmit_pin    = s.tx_pin;
  assign engine_abort        = s.init_req;
  assign sleep_mode          = s.sleep_ack;
  assign bus_if_clock_enable = s.clk_en;
  assign buf_wr              = s.buf_wr;
  assign buf_addr            = s.buf_addr;
  assign buf_data            = s.buf_data;

endmodule : ccc0_ctl

//--- dv/ccc0_ctl_sva.sv
// Checker of pin guard, time-stamp and clock-gate timing of the mode control zero block.
// Assumes it is bound to ccc0_ctl and sees only its ports.
`timescale 1ns/10ps
module ccc0_ctl_sva
  import ccc0_pkg::*;
(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire ccc0_engine_t engine,
  input wire logic         wait_mode,
  input wire logic         stop_mode,
  input wire logic         can_transmit_pin,
  input wire logic         engine_abort,
  input wire logic         sleep_mode,
  input wire logic         bus_if_clock_enable,
  input wire logic         buf_wr,
  input wire logic [3:0]   buf_addr
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  stop_recessive_a: assert property (stop_mode |=> can_transmit_pin)
    else $error("transmit pin not recessive in stop");
  abort_recessive_a: assert property (engine_abort |=> can_transmit_pin)
    else $error("transmit pin not recessive in init");
  sleep_recessive_a: assert property (sleep_mode |=> can_transmit_pin)
    else $error("transmit pin not recessive asleep");
  tx_follow_a: assert property (!(stop_mode || wait_mode || engine_abort || sleep_mode)
    |=> can_transmit_pin == $past(engine.tx_bit)) else $error("transmit pin lost engine bit");
  gate_release_a: assert property (!wait_mode |=> bus_if_clock_enable)
    else $error("bus clock gated outside wait");
  stamp_pair_a: assert property (buf_wr && buf_addr == CCC0_TS_BYTE_HI
    |=> buf_wr && buf_addr == CCC0_TS_BYTE_LO) else $error("low stamp byte missing");
  stamp_end_a: assert property (buf_wr && buf_addr == CCC0_TS_BYTE_LO |=> !buf_wr)
    else $error("stamp write too long");
  stamp_cause_a: assert property ($rose(buf_wr) |-> $past(engine.msg_acked)
    && buf_addr == CCC0_TS_BYTE_HI) else $error("stamp write without acknowledge");
  cover property (buf_wr);
  cover property ($rose(sleep_mode));
  cover property (!bus_if_clock_enable);
endmodule : ccc0_ctl_sva

bind ccc0_ctl ccc0_ctl_sva u_ccc0_ctl_sva (.hclk, .hresetn, .engine, .wait_mode, .stop_mode,
  .can_transmit_pin, .engine_abort, .sleep_mode, .bus_if_clock_enable, .buf_wr, .buf_addr);

//--- dv/ccc0_can_bus.sv
// Behavioural CAN bus seen through the transceiver, with one other node on it.
// Assumes a recessive-high bus on which any dominant node wins.
`timescale 1ns/10ps
module ccc0_can_bus (
  input  wire logic can_transmit_pin,
  input  wire logic other_dominant,
  output logic      can_receive_pin
);
  // Wired-and: our own bits echo back unless the other node pulls the bus dominant.
  assign can_receive_pin = can_transmit_pin & ~other_dominant;
endmodule : ccc0_can_bus

//--- dv/test_ccc0_ctl.sv
// Self-checking bench of the mode control zero block over AHB-Lite.
// Assumes the design answers with zero wait states; the bench still waits on hready.
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module test_ccc0_ctl
  import ccc0_pkg::*;
;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0, hreadyout, hresp, wait_mode = 1'b0, stop_mode = 1'b0;
  logic         can_rx, can_tx, abort, sleep_mode, clk_en, buf_wr, other_dom = 1'b0;
  logic [3:0]   buf_addr;
  logic [7:0]   buf_data;
  ccc0_engine_t engine = 8'h01; // Only the transmit bit starts high, which is recessive.
  int           num_errors = 0, num_checks = 0, cycles = 0;
  ccc0_ctl u_ccc0_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .engine(engine),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .can_receive_pin(can_rx),
    .can_transmit_pin(can_tx), .engine_abort(abort), .sleep_mode(sleep_mode),
    .bus_if_clock_enable(clk_en), .buf_wr(buf_wr), .buf_addr(buf_addr), .buf_data(buf_data));
  ccc0_can_bus u_ccc0_can_bus (.can_transmit_pin(can_tx), .other_dominant(other_dom),
    .can_receive_pin(can_rx));
  initial begin
    forever #20 hclk = ~hclk;
  end
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus
  task automatic t_init;
    bus(CCC0_OFS_CTL0, 0, 0);
    `CHK(rdv[7:0], 8'h01)
    engine.synced <= 1'b1;
    engine.frame_received <= 1'b1;
    bus(CCC0_OFS_CTL0, 1, 32'hff);
    engine.frame_received <= 1'b0;
    bus(CCC0_OFS_CTL0, 0, 0);
    `CHK(rdv[7:0], 8'h01)
    bus(CCC0_OFS_TIMER, 0, 0);
    `CHK(rdv[15:0], 16'h0000)
    bus(CCC0_OFS_CTL0, 1, 0);
    bus(CCC0_OFS_CTL0, 0, 0);
    `CHK(rdv[7:0], 8'h10)
    bus(CCC0_OFS_CTL1, 0, 0);
    `CHK({abort, rdv[1:0]}, 3'h0)
    $display("t_init done");
  endtask : t_init
  task automatic t_frame;
    engine.receiving <= 1'b1;
    engine.frame_received <= 1'b1;
    @(posedge hclk);
    engine.frame_received <= 1'b0;
    bus(CCC0_OFS_CTL0, 0, 0);
    `CHK(rdv[7:0], 8'hd0)
    bus(CCC0_OFS_CTL0, 1, 32'h50);
    bus(CCC0_OFS_CTL0, 0, 0);
    `CHK(rdv[7:0], 8'hd0)
    engine.receiving <= 1'b0;
    engine.synced <= 1'b0;
    bus(CCC0_OFS_CTL0, 1, 32'h80);
    bus(CCC0_OFS_CTL0, 0, 0);
    `CHK(rdv[7:0], 8'h00)
    $display("t_frame done");
  endtask : t_frame
  task automatic t_timer;
    bus(CCC0_OFS_CTL0, 1, 32'h08);
    repeat (5) begin
      engine.bit_tick <= 1'b1;
      @(posedge hclk);
      engine.bit_tick <= 1'b0;
      @(posedge hclk);
    end
    bus(CCC0_OFS_TIMER, 0, 0);
    `CHK(rdv[15:0], 16'h0005)
    engine.msg_acked <= 1'b1;
    @(posedge hclk);
    engine.msg_acked <= 1'b0;
    @(posedge hclk);
    `CHK({buf_wr, buf_addr, buf_data}, {1'b1, CCC0_TS_BYTE_HI, 8'h00})
    @(posedge hclk);
    `CHK({buf_wr, buf_addr, buf_data}, {1'b1, CCC0_TS_BYTE_LO, 8'h05})
    bus(CCC0_OFS_CTL0, 1, 0);
    bus(CCC0_OFS_TIMER, 0, 0);
    `CHK(rdv[15:0], 16'h0000)
    $display("t_timer done");
  endtask : t_timer
  task automatic t_wait;
    // A dominant engine bit makes the forced recessive level visible on the pin.
    engine.tx_bit <= 1'b0;
    bus(CCC0_OFS_CTL0, 1, 32'h20);
    `CHK(can_tx, 1'b0)
    wait_mode <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK({clk_en, can_tx}, 2'b01)
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK({clk_en, can_tx}, 2'b11)
    stop_mode <= 1'b0;
    engine.tx_bit <= 1'b1;
    bus(CCC0_OFS_CTL0, 1, 0);
    `CHK(can_tx, 1'b1)
    $display("t_wait done");
  endtask : t_wait
  task automatic t_sleep;
    engine.bus_idle <= 1'b1;
    engine.tx_empty <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      bus(CCC0_OFS_CTL0, 1, w ? 32'h04 : 32'h00);
      bus(CCC0_OFS_CTL0, 1, w ? 32'h06 : 32'h02);
      for (int i = 0; i < 20 && sleep_mode !== 1'b1; i++) @(posedge hclk);
      `CHK(sleep_mode, 1'b1)
      other_dom <= 1'b1;
      for (int i = 0; i < 20 && sleep_mode === 1'b1; i++) @(posedge hclk);
      other_dom <= 1'b0;
      bus(CCC0_OFS_CTL1, 0, 0);
      `CHK(rdv[2:0], w ? 3'b100 : 3'b010)
      bus(CCC0_OFS_CTL0, 1, 0);
      bus(CCC0_OFS_CTL1, 1, 32'h04);
    end
    $display("t_sleep done");
  endtask : t_sleep
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // The whole run needs well under a thousand cycles, so this ceiling only catches a hang.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_init;
    t_frame;
    t_timer;
    t_wait;
    t_sleep;
    tally_and_finish;
  end
endmodule : test_ccc0_ctl
